// [shared/dso_pkg.sv]
// shared constants for the burst-of-two sram core
`default_nettype none
package dso_pkg;
    localparam int unsigned LANE_W = 9;            // one byte lane incl. parity bit
    localparam int unsigned LANES = 4;             // lanes per beat
    localparam int unsigned DQ_W = LANE_W * LANES; // 36 data pins
    localparam int unsigned WORD_W = 2 * DQ_W;     // one array word holds both beats
    localparam int unsigned BE_W = 2 * LANES;      // lane enables for both beats
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DEPTH = 16;
    // pipeline taps, counted in half cycles of the k clock (one clock_i edge each)
    localparam int unsigned SR_W = 6;
    localparam int unsigned TAP_HOLD = 1;          // read word latched at k rise n+1
    localparam int unsigned TAP_BEAT1 = 1;         // write beat 1 at k rise n+1
    localparam int unsigned TAP_BEAT2 = 2;         // write beat 2 at k# rise n+1.5
    localparam int unsigned TAP_COMMIT = 3;        // merged write into the array
    localparam int unsigned TAP_DRV_A = 3;         // drivers on from k rise n+2
    localparam int unsigned TAP_DRV_B = 4;
    localparam int unsigned TAP_TOFF_LO = 2;       // termination off half a cycle early
    localparam int unsigned TAP_TOFF_HI = 5;       // and back half a cycle late
    // impedance tracking
    localparam int unsigned CLK_PERIOD_NS = 50;
    localparam int unsigned CAL_INTERVAL_CYC = 1024;
    localparam int unsigned CAL_CNT_W = 10;
    localparam int unsigned CAL_CODE_W = 4;
    localparam logic [CAL_CODE_W-1:0] CAL_CODE_RST = 4'h8;
    localparam logic [CAL_CODE_W-1:0] CAL_CODE_MAX = 4'hf;
    localparam logic [CAL_CODE_W-1:0] CAL_CODE_MIN = 4'h0;
endpackage : dso_pkg
`default_nettype wire

// [rtl/dso_mem.sv]
// word array with per-lane write enables and registered read data
`default_nettype none
module dso_mem (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic rd_en_i,
    input wire logic [dso_pkg::ADDR_W-1:0] rd_addr_i,
    output logic [dso_pkg::WORD_W-1:0] rd_data_o,
    input wire logic [dso_pkg::BE_W-1:0] wr_be_i,
    input wire logic [dso_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [dso_pkg::WORD_W-1:0] wr_data_i
);
    import dso_pkg::*;

    wire logic [WORD_W-1:0] lane_rd;
    logic [WORD_W-1:0] next_rd_data;

    // one small store per lane, so no lane process ever writes another lane's store
    for (genvar g = 0; g < BE_W; g++) begin : g_lane
        logic [LANE_W-1:0] lane_mem [DEPTH];
        // masked lanes get no enable and keep their old contents
        always_ff @(posedge clock_i) begin
            if (wr_be_i[g]) begin
                lane_mem[wr_addr_i] <= wr_data_i[g*LANE_W +: LANE_W];
            end
        end
        assign lane_rd[g*LANE_W +: LANE_W] = lane_mem[rd_addr_i];
    end

    // read data held until the next read
    always_comb begin
        next_rd_data = rd_en_i ? lane_rd : rd_data_o;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= next_rd_data;
        end
    end
endmodule : dso_mem
`default_nettype wire

// [rtl/dso_sram.sv]
// command decode, data pipeline, termination and impedance tracking
`default_nettype none
// Functional notes
// RULE1: termination pin low or open keeps all input termination off.
// RULE2: termination pin high turns on data, mask and clock termination.
// RULE3: termination impedance recalibrated periodically, sharing the driver calibration code.
// RULE4: controller must never float mask or clock inputs while termination is on.
// RULE5: with termination on, data termination on for writes and idle, off for reads.
// RULE6: data termination off half cycle before drivers on, back half cycle after.
// RULE7: controller drives data for writes and idle, releases and terminates for reads.
// RULE8: controller should shorten terminated-but-undriven gaps around read turnarounds.
// RULE9: drivers off one cycle starting two cycles after idle or write command.
// RULE10: during that driver-off cycle the data level comes from termination.
// RULE11: lane stored per beat when its low-active mask is low at that beat.
// RULE12: all masks high on both beats aborts the write, array unchanged.
// RULE13: load strobe high is deselect; drivers idle once pending bursts finish.
// RULE14: controller presents beat one at next k rise, beat two at k# rise.
// RULE15: mask bit n governs data bits 9n to 9n+8.
// RULE16: every read or write moves exactly two beats; commands may issue every cycle.
// RULE17: read data beats start at the second k rise after the command.
// RULE18: write data merged into the array at the command address, masked lanes kept.
module dso_sram (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic load_strobe_n_i,
    input wire logic read_not_write_i,
    input wire logic [dso_pkg::ADDR_W-1:0] addr_i,
    input wire logic [dso_pkg::DQ_W-1:0] dq_i,
    input wire logic [dso_pkg::LANES-1:0] byte_write_mask_n_i,
    input wire logic termination_enable_pin_i,
    input wire logic impedance_compare_i,
    output logic k_phase_o,
    output logic [dso_pkg::DQ_W-1:0] dq_o,
    output logic dq_oe_o,
    output logic term_data_o,
    output logic term_ctrl_o,
    output logic [dso_pkg::CAL_CODE_W-1:0] imp_code_o
);
    import dso_pkg::*;

    // ---- strap and comparator synchronisers, impedance tracking ----
    logic [2:0] term_sync;
    logic [2:0] cmp_sync;
    logic term_on;
    logic cmp_hi;
    logic [CAL_CNT_W-1:0] cal_cnt;
    logic cal_tick;
    logic [2:0] next_term_sync;
    logic [2:0] next_cmp_sync;
    logic next_term_on;
    logic next_cmp_hi;
    logic [CAL_CNT_W-1:0] next_cal_cnt;
    logic next_cal_tick;
    logic [CAL_CODE_W-1:0] next_imp_code;

    // a level only counts once the 2nd and 3rd stages agree
    always_comb begin
        next_term_sync = {term_sync[1:0], termination_enable_pin_i};
        next_cmp_sync = {cmp_sync[1:0], impedance_compare_i};
        next_term_on = (term_sync[1] == term_sync[2]) ? term_sync[2] : term_on; // RULE1 RULE2
        next_cmp_hi = (cmp_sync[1] == cmp_sync[2]) ? cmp_sync[2] : cmp_hi;
        next_cal_tick = (cal_cnt == CAL_CNT_W'(CAL_INTERVAL_CYC - 1));
        next_cal_cnt = next_cal_tick ? '0 : cal_cnt + 1'b1;
        next_imp_code = imp_code_o;
        // one step per evaluation so a noisy compare cannot jolt the impedance
        if (cal_tick) begin // RULE3
            if (cmp_hi && imp_code_o != CAL_CODE_MAX) begin
                next_imp_code = imp_code_o + 1'b1;
            end else if (!cmp_hi && imp_code_o != CAL_CODE_MIN) begin
                next_imp_code = imp_code_o - 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_sync <= '0;
            cmp_sync <= '0;
            term_on <= 1'b0;
            cmp_hi <= 1'b0;
            cal_cnt <= '0;
            cal_tick <= 1'b0;
            imp_code_o <= CAL_CODE_RST;
        end else begin
            term_sync <= next_term_sync;
            cmp_sync <= next_cmp_sync;
            term_on <= next_term_on;
            cmp_hi <= next_cmp_hi;
            cal_cnt <= next_cal_cnt;
            cal_tick <= next_cal_tick;
            imp_code_o <= next_imp_code;
        end
    end

    // ---- command pipeline and data path ----
    logic [SR_W-1:0] rd_sr;
    logic [SR_W-1:0] wr_sr;
    logic [ADDR_W-1:0] wa_cmd;
    logic [ADDR_W-1:0] wa_data;
    logic [DQ_W-1:0] wd_lo;
    logic [DQ_W-1:0] wd_hi;
    logic [LANES-1:0] be_lo;
    logic [LANES-1:0] be_hi;
    logic [WORD_W-1:0] rd_hold;
    logic [DQ_W-1:0] rd_hi_pend;
    logic [WORD_W-1:0] mem_rdata;
    logic sample_edge;
    logic push_rd;
    logic push_wr;
    logic [BE_W-1:0] commit_be;
    logic [SR_W-1:0] next_rd_sr;
    logic [SR_W-1:0] next_wr_sr;
    logic [ADDR_W-1:0] next_wa_cmd;
    logic [ADDR_W-1:0] next_wa_data;
    logic [DQ_W-1:0] next_wd_lo;
    logic [DQ_W-1:0] next_wd_hi;
    logic [LANES-1:0] next_be_lo;
    logic [LANES-1:0] next_be_hi;
    logic [WORD_W-1:0] next_rd_hold;
    logic [DQ_W-1:0] next_rd_hi_pend;
    logic [DQ_W-1:0] next_dq;
    logic next_dq_oe;
    logic next_term_data;

    // k_phase_o low means the coming edge is a k rise; commands are taken only then
    assign sample_edge = !k_phase_o;
    assign push_rd = sample_edge && !load_strobe_n_i && read_not_write_i; // RULE13 RULE17
    assign push_wr = sample_edge && !load_strobe_n_i && !read_not_write_i; // RULE13
    // an all-masked write yields no lane enable, so the array is left alone
    assign commit_be = wr_sr[TAP_COMMIT] ? {be_hi, be_lo} : '0; // RULE12 RULE18

    always_comb begin
        // every accepted command occupies exactly its own slots; overlap is fine
        next_rd_sr = {rd_sr[SR_W-2:0], push_rd}; // RULE16
        next_wr_sr = {wr_sr[SR_W-2:0], push_wr}; // RULE16
        next_wa_cmd = push_wr ? addr_i : wa_cmd;
        next_wa_data = wa_data;
        next_wd_lo = wd_lo;
        next_wd_hi = wd_hi;
        next_be_lo = be_lo;
        next_be_hi = be_hi;
        if (wr_sr[TAP_BEAT1]) begin // RULE11
            next_wa_data = wa_cmd;
            next_wd_lo = dq_i;
            next_be_lo = ~byte_write_mask_n_i; // RULE15
        end
        if (wr_sr[TAP_BEAT2]) begin // RULE11
            next_wd_hi = dq_i;
            next_be_hi = ~byte_write_mask_n_i; // RULE15
        end
        // latched early so a back-to-back read cannot overwrite it mid-burst
        next_rd_hold = rd_sr[TAP_HOLD] ? mem_rdata : rd_hold;
        next_rd_hi_pend = rd_sr[TAP_DRV_A] ? rd_hold[WORD_W-1:DQ_W] : rd_hi_pend;
        next_dq = dq_o;
        if (rd_sr[TAP_DRV_A]) begin // RULE17
            next_dq = rd_hold[DQ_W-1:0];
        end else if (rd_sr[TAP_DRV_B]) begin
            next_dq = rd_hi_pend;
        end
        // drivers only in read beat slots; idle or write slots stay tri-stated
        next_dq_oe = rd_sr[TAP_DRV_A] || rd_sr[TAP_DRV_B]; // RULE9 RULE13 RULE17
        // termination window wraps the driver window by half a cycle each side
        next_term_data = term_on && !(|rd_sr[TAP_TOFF_HI:TAP_TOFF_LO]); // RULE5 RULE6 RULE10
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            k_phase_o <= 1'b0;
            rd_sr <= '0;
            wr_sr <= '0;
            wa_cmd <= '0;
            wa_data <= '0;
            wd_lo <= '0;
            wd_hi <= '0;
            be_lo <= '0;
            be_hi <= '0;
            rd_hold <= '0;
            rd_hi_pend <= '0;
            dq_o <= '0;
            dq_oe_o <= 1'b0;
            term_data_o <= 1'b0;
            term_ctrl_o <= 1'b0;
        end else begin
            k_phase_o <= !k_phase_o;
            rd_sr <= next_rd_sr;
            wr_sr <= next_wr_sr;
            wa_cmd <= next_wa_cmd;
            wa_data <= next_wa_data;
            wd_lo <= next_wd_lo;
            wd_hi <= next_wd_hi;
            be_lo <= next_be_lo;
            be_hi <= next_be_hi;
            rd_hold <= next_rd_hold;
            rd_hi_pend <= next_rd_hi_pend;
            dq_o <= next_dq;
            dq_oe_o <= next_dq_oe;
            term_data_o <= next_term_data;
            term_ctrl_o <= term_on; // RULE1 RULE2
        end
    end

    // array: read on the command edge, merged write two cycles later
    dso_mem u_mem (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .rd_en_i(push_rd),
        .rd_addr_i(addr_i),
        .rd_data_o(mem_rdata),
        .wr_be_i(commit_be),
        .wr_addr_i(wa_data),
        .wr_data_i({wd_hi, wd_lo})
    );

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    AST_TERM_OFF_LOW: assert property (!$past(term_on) |-> !term_ctrl_o && !term_data_o) // RULE1
        else $error("termination on while strap low");
    AST_TERM_ON_HIGH: assert property ($past(term_on) |-> term_ctrl_o) // RULE2
        else $error("mask and clock termination off while strap high");
    AST_CAL_ONLY_ON_TICK: assert property ($changed(imp_code_o) |-> $past(cal_tick)) // RULE3
        else $error("impedance code moved outside an evaluation");
    AST_NO_TERM_WHILE_DRIVING: assert property (dq_oe_o |-> !term_data_o) // RULE5
        else $error("data termination on while drivers on");
    AST_TERM_LEAD: assert property ($rose(dq_oe_o) |-> !$past(term_data_o)) // RULE6
        else $error("termination not removed half a cycle before drive");
    AST_TERM_TRAIL: assert property ($fell(dq_oe_o) |-> !term_data_o) // RULE6
        else $error("termination restored too early after drive");
    AST_DRV_OFF_AFTER_IDLE: assert property (
        sample_edge && !(!load_strobe_n_i && read_not_write_i)
        |-> ##5 !dq_oe_o ##1 !dq_oe_o) // RULE9
        else $error("drivers on after idle or write command");
    AST_READ_BEATS: assert property (push_rd |-> ##5 dq_oe_o ##1 dq_oe_o) // RULE17
        else $error("read beats not driven at second k rise");
    AST_ABORT_NO_WRITE: assert property (
        wr_sr[TAP_COMMIT] && (&$past(byte_write_mask_n_i))
        && (&$past(byte_write_mask_n_i, 2)) |-> commit_be == '0) // RULE12
        else $error("fully masked write reached the array");
    AST_LANE_ENABLES: assert property (wr_sr[TAP_COMMIT]
        |-> commit_be == ~{$past(byte_write_mask_n_i), $past(byte_write_mask_n_i, 2)}) // RULE11
        else $error("lane enables differ from the beat masks");
endmodule : dso_sram
`default_nettype wire

// [verification/dso_ctrl_model.sv]
// memory controller model: commands, write beats and dq bus level
`default_nettype none
module dso_ctrl_model (
    input wire logic clock_i,
    input wire logic k_phase_i,
    input wire logic dq_oe_i,
    input wire logic [dso_pkg::DQ_W-1:0] dq_dev_i,
    output logic load_strobe_n_o,
    output logic read_not_write_o,
    output logic [dso_pkg::ADDR_W-1:0] addr_o,
    output logic [dso_pkg::LANES-1:0] mask_n_o,
    output logic [dso_pkg::DQ_W-1:0] dq_bus_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import dso_pkg::*;
    logic [DQ_W-1:0] ctrl_dq = '0;
    logic ctrl_oe = 1'b1;
    int cyc = 0;
    int win_start = 0;
    int win_end = 0;
    // masks always driven to a level, never floating
    initial begin
        load_strobe_n_o = 1'b1;
        read_not_write_o = 1'b0;
        addr_o = '0;
        mask_n_o = '1;
    end
    // released bus shows the inverse of the last level, not a kept value
    assign dq_bus_o = dq_oe_i ? dq_dev_i : (ctrl_oe ? ctrl_dq : ~ctrl_dq);
    // counted on the falling edge so tasks see it stable at rising edges
    always @(negedge clock_i) cyc <= cyc + 1;
    // drive dq except across our own read windows, matching termination
    always @(posedge clock_i) ctrl_oe <= !(cyc >= win_start && cyc < win_end);
    // command driven on a phase-1 edge so it is taken on the next k rise
    task automatic send_cmd(input logic rd, input logic [ADDR_W-1:0] a);
        @(negedge clock_i);
        if (k_phase_i !== 1'b1) @(negedge clock_i);
        @(posedge clock_i);
        load_strobe_n_o <= 1'b0;
        read_not_write_o <= rd;
        addr_o <= a;
        @(posedge clock_i);
        load_strobe_n_o <= 1'b1;
        if (rd && cyc >= win_end) win_start = cyc + 3;
        if (rd) win_end = cyc + 7;
    endtask
    // late write: beat one for the next k rise, beat two for the k# rise
    task automatic write_word(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
        input logic [BE_W-1:0] m);
        send_cmd(1'b0, a);
        @(posedge clock_i);
        ctrl_dq <= d[DQ_W-1:0];
        mask_n_o <= m[LANES-1:0];
        @(posedge clock_i);
        ctrl_dq <= d[WORD_W-1:DQ_W];
        mask_n_o <= m[BE_W-1:LANES];
        @(posedge clock_i);
        mask_n_o <= '1;
    endtask
endmodule // dso_ctrl_model
`default_nettype wire

// [verification/ddr_sram_odt_byte_write_bench.sv]
// self-checking bench for the burst-of-two sram core
`default_nettype none
module ddr_sram_odt_byte_write_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import dso_pkg::*;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic strap = 1'b0;
    logic cmp = 1'b0;
    logic strobe_n, rw, k_phase, dq_oe, term_data, term_ctrl;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] mask_n;
    logic [DQ_W-1:0] dq_bus, dq_dev;
    logic [CAL_CODE_W-1:0] imp_code;
    logic [WORD_W-1:0] mem [DEPTH];
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;
    dso_sram i_dso_sram (.clock_i(clock_i), .rst_n_i(rst_n_i), .load_strobe_n_i(strobe_n),
        .read_not_write_i(rw), .addr_i(addr), .dq_i(dq_bus), .byte_write_mask_n_i(mask_n),
        .termination_enable_pin_i(strap), .impedance_compare_i(cmp), .k_phase_o(k_phase),
        .dq_o(dq_dev), .dq_oe_o(dq_oe), .term_data_o(term_data), .term_ctrl_o(term_ctrl),
        .imp_code_o(imp_code));
    dso_ctrl_model i_dso_ctrl_model (.clock_i(clock_i), .k_phase_i(k_phase),
        .dq_oe_i(dq_oe), .dq_dev_i(dq_dev), .load_strobe_n_o(strobe_n),
        .read_not_write_o(rw), .addr_o(addr), .mask_n_o(mask_n), .dq_bus_o(dq_bus));
    task automatic complete_run();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // a hang ends here; ceiling covers two calibration intervals plus margin
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            failures++;
            complete_run();
        end
    end
    task automatic check(input string what, input logic [WORD_W-1:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // lane n of the word kept unless its low-active mask bit is low
    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, n,
        input logic [BE_W-1:0] m);
        for (int i = 0; i < BE_W; i++)
            if (!m[i]) o[i*LANE_W +: LANE_W] = n[i*LANE_W +: LANE_W];
        return o;
    endfunction
    // write, then the driver-off slot two cycles after the command
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d,
        input logic [BE_W-1:0] m);
        i_dso_ctrl_model.write_word(a, d, m);
        mem[a] = merge(mem[a], d, m);
        @(posedge clock_i);
        @(negedge clock_i);
        check("gap oe", dq_oe, 1'b0);
        check("k phase", k_phase, 1'b1);
        @(negedge clock_i);
        check("gap oe", dq_oe, 1'b0);
        check("k phase", k_phase, 1'b0);
        check("gap term", term_data, strap);
    endtask
    // single read: beats and oe/term levels after edges two to seven
    task automatic rd_check(input logic [ADDR_W-1:0] a, input logic [5:0] tm_exp);
        logic [WORD_W-1:0] d;
        logic [5:0] oe;
        logic [5:0] tm;
        i_dso_ctrl_model.send_cmd(1'b1, a);
        repeat (2) @(posedge clock_i);
        for (int i = 0; i < 6; i++) begin
            @(negedge clock_i);
            oe[i] = dq_oe;
            tm[i] = term_data;
            if (i == 2) d[DQ_W-1:0] = dq_bus;
            if (i == 3) d[WORD_W-1:DQ_W] = dq_bus;
            if (i < 5) @(posedge clock_i);
        end
        check("read word", d, mem[a]);
        check("oe slots", oe, 6'h0c);
        check("term slots", tm, tm_exp);
    endtask
    task automatic t_strap_off();
        check("imp reset", imp_code, CAL_CODE_RST);
        wr(4'h1, {8{9'h155}}, 8'h00);
        wr(4'h2, {8{9'h0aa}}, 8'h00);
        rd_check(4'h1, 6'h00);
        check("term ctrl", term_ctrl, 1'b0);
        $display("test strap_off done");
    endtask
    task automatic t_strap_on();
        @(posedge clock_i);
        strap <= 1'b1;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        check("term ctrl", term_ctrl, 1'b1);
        check("term data", term_data, 1'b1);
        rd_check(4'h2, 6'h21);
        $display("test strap_on done");
    endtask
    // beat one and beat two each open a different lane
    task automatic t_masks();
        for (int n = 0; n < LANES; n++) begin
            wr(4'h3, {8{9'h0f0}}, 8'h00);
            wr(4'h3, {8{9'h10f}} ^ WORD_W'(n), ~((8'h01 << n) | (8'h80 >> n)));
            rd_check(4'h3, 6'h21);
        end
        wr(4'h3, ~mem[3], 8'hff);
        rd_check(4'h3, 6'h21);
        $display("test masks done");
    endtask
    task automatic t_b2b_reads();
        logic [2*WORD_W-1:0] d;
        logic [5:0] oe;
        i_dso_ctrl_model.send_cmd(1'b1, 4'h1);
        i_dso_ctrl_model.send_cmd(1'b1, 4'h2);
        for (int i = 0; i < 6; i++) begin
            @(posedge clock_i);
            @(negedge clock_i);
            oe[i] = dq_oe;
            if (i > 0 && i < 5) d[(i-1)*DQ_W +: DQ_W] = dq_bus;
        end
        check("b2b oe", oe, 6'h1e);
        check("b2b first", d[WORD_W-1:0], mem[1]);
        check("b2b second", d[2*WORD_W-1:WORD_W], mem[2]);
        $display("test b2b_reads done");
    endtask
    task automatic wait_code(input logic [CAL_CODE_W-1:0] exp);
        logic [CAL_CODE_W-1:0] c;
        c = imp_code;
        for (int i = 0; i < 1100 && imp_code === c; i++) @(posedge clock_i);
        @(negedge clock_i);
        check("imp code", imp_code, exp);
    endtask
    // low compare steps the code down, high steps it back up
    task automatic t_cal();
        wait_code(imp_code - 4'h1);
        @(posedge clock_i);
        cmp <= 1'b1;
        wait_code(imp_code + 4'h1);
        $display("test cal done");
    endtask
    // mid-run reset: outputs drop to reset levels, strap resyncs, array survives
    task automatic t_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        @(negedge clock_i);
        check("rst term", {term_ctrl, term_data, dq_oe}, 3'b000);
        check("rst imp", imp_code, CAL_CODE_RST);
        check("rst phase", k_phase, 1'b0);
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        @(negedge clock_i);
        check("rst term ctrl", term_ctrl, 1'b1);
        rd_check(4'h1, 6'h21);
        $display("test reset done");
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        t_strap_off();
        t_strap_on();
        t_masks();
        t_b2b_reads();
        t_cal();
        t_reset();
        complete_run();
    end
endmodule // ddr_sram_odt_byte_write_bench
`default_nettype wire
